// ### snvc_buf2.v
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: flush drops every entry in one cycle
// Notes:   in_ready is low only when both entries hold data
`timescale 1ns/100ps
`default_nettype none
`include "snvc_defs.vh"

module snvc_buf2 (
    input  wire                      clk,
    input  wire                      reset,
    input  wire                      flush,
    input  wire                      in_valid,
    output wire                      in_ready,
    input  wire [`SNVC_DW-1:0]       in_data,
    output wire                      out_valid,
    input  wire                      out_ready,
    output wire [`SNVC_DW-1:0]       out_data
);

    reg [`SNVC_DW-1:0] ent0_q;
    reg [`SNVC_DW-1:0] ent1_q;
    reg [1:0]          cnt_q;
    wire               push;
    wire               pop;

    assign in_ready  = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data  = ent0_q;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // entry 0 is always the head; entry 1 moves up on a pop
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_q  <= 2'h0;
            ent0_q <= 8'h00;
            ent1_q <= 8'h00;
        end else if (flush) begin
            cnt_q <= 2'h0;
        end else begin
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
            if (pop) begin
                ent0_q <= (push && cnt_q == 2'h1) ? in_data : ent1_q;
            end else if (push && cnt_q == 2'h0) begin
                ent0_q <= in_data;
            end
            if (push && (cnt_q == 2'h2 || (cnt_q == 2'h1 && !pop))) begin
                ent1_q <= in_data;
            end
        end
    end

endmodule // snvc_buf2
`default_nettype wire

// ### snvc_defs.vh
// Purpose: constants shared by the serial nonvolatile command slave
// Assumes: included by bare name from each design file
// Notes:   definitions only
`ifndef SNVC_DEFS_VH
`define SNVC_DEFS_VH

// ----------------------------------------------------------------
// opcodes, msb first on the serial input
// ----------------------------------------------------------------
`define SNVC_OP_SET_LATCH   8'h06
`define SNVC_OP_CLR_LATCH   8'h04
`define SNVC_OP_STAT_READ   8'h05
`define SNVC_OP_STAT_WRITE  8'h01
`define SNVC_OP_MEM_READ    8'h03
`define SNVC_OP_MEM_WRITE   8'h02
`define SNVC_OP_IDENT_READ  8'h9F

// ----------------------------------------------------------------
// status_config field positions and reset value
// ----------------------------------------------------------------
`define SNVC_ST_GUARD       7
`define SNVC_ST_SPARE_HI    6
`define SNVC_ST_SPARE_LO    4
`define SNVC_ST_BLK_HI      3
`define SNVC_ST_BLK_LO      2
`define SNVC_ST_WEL         1
`define SNVC_ST_ZERO        0
`define SNVC_ST_RESET       8'h00

// ----------------------------------------------------------------
// bit counts and memory shape
// ----------------------------------------------------------------
`define SNVC_CNT_W          4
`define SNVC_BYTE_LAST      4'h7
`define SNVC_ADDR_LAST      4'hF
`define SNVC_AW             11
`define SNVC_DEPTH          2048
`define SNVC_DW             8

`endif

// ### snvc_host.sv
// Purpose: behavioural host master driving the serial link
// Assumes: mode 0 or 3, one bit per 16 clk (80 ns), clock parked
// Notes:   a released output is seen as the inverse of its last bit
`timescale 1ns/100ps
`default_nettype none

module snvc_host (
    input  wire logic clk,
    input  wire logic so,
    input  wire logic so_oe,
    output var  logic sck,
    output var  logic cs_n,
    output var  logic si,
    output var  logic hold_n,
    output var  logic wp_n
);
    logic last_bit;
    logic mode3;

    // ------------------------------------------------------------
    // pin idle state and frame tasks
    // ------------------------------------------------------------
    // host owns clock and select, clock stands low outside frames in mode 0, high in mode 3
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        hold_n = 1'b1;
        wp_n = 1'b1;
        last_bit = 1'b0;
        mode3 = 1'b0;
    end

    task automatic start();
        cs_n <= 1'b0;
        repeat (8) @(posedge clk);
    endtask

    // gap after select rise keeps frames well apart
    task automatic stop();
        repeat (8) @(posedge clk);
        cs_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask

    // msb first; data changes on the fall, read just before the rise
    task automatic shift(input logic [7:0] tx, input int n,
                         output logic [7:0] rx);
        for (int i = 7; i > 7 - n; i--) begin
            if (mode3) sck <= 1'b0;
            si <= tx[i];
            repeat (8) @(posedge clk);
            last_bit = so_oe ? so : ~last_bit;
            rx = {rx[6:0], last_bit};
            sck <= 1'b1;
            repeat (8) @(posedge clk);
            if (!mode3) sck <= 1'b0;
        end
    endtask

    // pause with the clock parked low, select kept low; hold waits
    // for the last fall to be taken, else that fall is lost
    task automatic pause();
        repeat (8) @(posedge clk);
        hold_n <= 1'b0;
        repeat (16) @(posedge clk);
        hold_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask

    // only called between frames so the level is steady per command
    task automatic set_wp(input logic v);
        wp_n <= v;
        @(posedge clk);
    endtask

    // park level moves only while deselected, so no edge is seen
    task automatic set_mode(input logic m);
        mode3 = m;
        sck <= m;
        repeat (8) @(posedge clk);
    endtask
endmodule // snvc_host

`default_nettype wire

// ### snvc_mem.v
// Purpose: 2K x 8 storage array with registered read data
// Assumes: single clock, one read and one write port
// Notes:   read data appear one cycle after rd_en
`timescale 1ns/100ps
`default_nettype none
`include "snvc_defs.vh"

module snvc_mem (
    input  wire                      clk,
    input  wire                      wr_en,
    input  wire [`SNVC_AW-1:0]       wr_addr,
    input  wire [`SNVC_DW-1:0]       wr_data,
    input  wire                      rd_en,
    input  wire [`SNVC_AW-1:0]       rd_addr,
    output reg  [`SNVC_DW-1:0]       rd_data_q
);

    reg [`SNVC_DW-1:0] cells [0:`SNVC_DEPTH-1];

    // no reset on the array: contents are meant to persist
    always @(posedge clk) begin
        if (wr_en) begin
            cells[wr_addr] <= wr_data;
        end
        if (rd_en) begin
            rd_data_q <= cells[rd_addr];
        end
    end

endmodule // snvc_mem
`default_nettype wire

// ### snvc_slave.v
// Purpose: serial-slave command front end of a 2K x 8 nonvolatile memory
// Assumes: serial pins are asynchronous and far slower than clk
// Notes:   every serial pin passes two flip-flops before any logic reads it; write_region_ok is read directly
`timescale 1ns/100ps
`default_nettype none
`include "snvc_defs.vh"

module snvc_slave (
    input  wire                      clk,
    input  wire                      reset,
    input  wire                      sck,
    input  wire                      cs_n,
    input  wire                      si,
    input  wire                      hold_n,
    input  wire                      wp_n,
    input  wire                      write_region_ok,
    output reg                       so_q,
    output reg                       so_oe_q,
    output reg  [1:0]                block_guard_q,
    output reg                       status_write_guard_q
);

    // ----------------------------------------------------------------
    // command states
    // ----------------------------------------------------------------
    localparam [2:0] ST_OPCODE = 3'h0;
    localparam [2:0] ST_ADDR   = 3'h1;
    localparam [2:0] ST_SREAD  = 3'h2;
    localparam [2:0] ST_SWRITE = 3'h3;
    localparam [2:0] ST_MREAD  = 3'h4;
    localparam [2:0] ST_MWRITE = 3'h5;
    localparam [2:0] ST_DONE   = 3'h6;
    localparam [7:0] RST_VAL   = `SNVC_ST_RESET;

    // true in the states that drive the serial output
    function is_out_state;
        input [2:0] st;
        begin
            is_out_state = (st == ST_SREAD) || (st == ST_MREAD);
        end
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    reg  sck_s1_q, sck_s2_q, sck_s3_q;
    reg  cs_s1_q, cs_s2_q, cs_s3_q;
    reg  si_s1_q, si_s2_q;
    reg  hold_s1_q, hold_s2_q;
    reg  wp_s1_q, wp_s2_q;

    // first stages feed only the second; edges use stages two and three
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            sck_s1_q  <= 1'b0;
            sck_s2_q  <= 1'b0;
            sck_s3_q  <= 1'b0;
            cs_s1_q   <= 1'b1;
            cs_s2_q   <= 1'b1;
            cs_s3_q   <= 1'b1;
            si_s1_q   <= 1'b0;
            si_s2_q   <= 1'b0;
            hold_s1_q <= 1'b1;
            hold_s2_q <= 1'b1;
            wp_s1_q   <= 1'b1;
            wp_s2_q   <= 1'b1;
        end else begin
            sck_s1_q  <= sck;
            sck_s2_q  <= sck_s1_q;
            sck_s3_q  <= sck_s2_q;
            cs_s1_q   <= cs_n;
            cs_s2_q   <= cs_s1_q;
            cs_s3_q   <= cs_s2_q;
            si_s1_q   <= si;
            si_s2_q   <= si_s1_q;
            hold_s1_q <= hold_n;
            hold_s2_q <= hold_s1_q;
            wp_s1_q   <= wp_n;
            wp_s2_q   <= wp_s1_q;
        end
    end

    // clock edges count only while selected and not held; the select rise is not gated by hold
    wire active   = !cs_s2_q && hold_s2_q;
    wire sck_rise = active && sck_s2_q && !sck_s3_q;
    wire sck_fall = active && !sck_s2_q && sck_s3_q;
    wire cs_rise  = cs_s2_q && !cs_s3_q;

    // ----------------------------------------------------------------
    // command state and shift registers
    // ----------------------------------------------------------------
    reg  [2:0]                state_q;
    reg  [`SNVC_CNT_W-1:0]    cnt_q;
    reg  [7:0]                rx_q;
    reg  [`SNVC_AW-1:0]       addr_q;
    reg  [`SNVC_AW-1:0]       rd_addr_q;
    reg                       wr_seen_q;
    reg                       rd_pend_q;
    reg                       inflight_q;
    reg  [7:0]                tx_q;
    reg  [2:0]                tx_cnt_q;
    reg                       wel_q;
    reg  [2:0]                spare_q;
    reg                       mem_wr_q;
    reg  [`SNVC_AW-1:0]       mem_wa_q;
    reg  [7:0]                mem_wd_q;

    wire [7:0] rx_next = {rx_q[6:0], si_s2_q};
    wire       buf_in_ready;
    wire       buf_out_valid;
    wire [7:0] buf_out_data;
    wire [7:0] mem_rd_data;
    wire       mem_rd_en = rd_pend_q && !inflight_q && buf_in_ready;
    wire       pop       = sck_fall && state_q == ST_MREAD && tx_cnt_q == 3'h0;
    wire       flush     = cs_s2_q;

    // status byte as the host sees it; bit 0 always zero
    wire [7:0] status_view = {status_write_guard_q, spare_q,
                              block_guard_q, wel_q, 1'b0};

    // status writes need the latch and, if guarded, wp high
    wire status_wr_ok = wel_q &&
                        !(status_write_guard_q && !wp_s2_q);

    // ----------------------------------------------------------------
    // rising-edge command decode and input capture
    // ----------------------------------------------------------------
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q              <= ST_OPCODE;
            cnt_q                <= 4'h0;
            rx_q                 <= 8'h00;
            addr_q               <= {`SNVC_AW{1'b0}};
            wr_seen_q            <= 1'b0;
            wel_q                <= RST_VAL[`SNVC_ST_WEL];
            status_write_guard_q <= RST_VAL[`SNVC_ST_GUARD];
            spare_q              <=
                RST_VAL[`SNVC_ST_SPARE_HI:`SNVC_ST_SPARE_LO];
            block_guard_q        <= RST_VAL[`SNVC_ST_BLK_HI:`SNVC_ST_BLK_LO];
            mem_wr_q             <= 1'b0;
            mem_wa_q             <= {`SNVC_AW{1'b0}};
            mem_wd_q             <= 8'h00;
        end else begin
            mem_wr_q <= 1'b0;
            if (cs_s2_q) begin
                // deselect drops any partial opcode unperformed
                state_q <= ST_OPCODE;
                cnt_q   <= 4'h0;
                if (cs_rise && wr_seen_q) begin
                    wel_q <= 1'b0;
                end
                wr_seen_q <= 1'b0;
            end else if (sck_rise) begin
                rx_q  <= rx_next;
                cnt_q <= cnt_q + 4'h1;
                case (state_q)
                ST_OPCODE: begin
                    if (cnt_q == `SNVC_BYTE_LAST) begin
                        cnt_q <= 4'h0;
                        // undefined codes are the host's fault; park
                        case (rx_next)
                        `SNVC_OP_SET_LATCH: begin
                            wel_q   <= 1'b1;
                            state_q <= ST_DONE;
                        end
                        `SNVC_OP_CLR_LATCH: begin
                            wel_q   <= 1'b0;
                            state_q <= ST_DONE;
                        end
                        `SNVC_OP_STAT_READ: begin
                            state_q <= ST_SREAD;
                        end
                        `SNVC_OP_STAT_WRITE: begin
                            state_q   <= ST_SWRITE;
                            wr_seen_q <= 1'b1;
                        end
                        `SNVC_OP_MEM_READ: begin
                            state_q <= ST_ADDR;
                        end
                        `SNVC_OP_MEM_WRITE: begin
                            state_q   <= ST_ADDR;
                            wr_seen_q <= 1'b1;
                        end
                        default: begin
                            state_q <= ST_DONE;
                        end
                        endcase
                    end
                end
                ST_ADDR: begin
                    // only the low 11 of 16 bits survive
                    addr_q <= {addr_q[`SNVC_AW-2:0], si_s2_q};
                    if (cnt_q == `SNVC_ADDR_LAST) begin
                        cnt_q   <= 4'h0;
                        state_q <= wr_seen_q ? ST_MWRITE : ST_MREAD;
                        mem_wa_q <= {addr_q[`SNVC_AW-2:0], si_s2_q};
                    end
                end
                ST_SWRITE: begin
                    if (cnt_q == `SNVC_BYTE_LAST) begin
                        state_q <= ST_DONE;
                        if (status_wr_ok) begin
                            status_write_guard_q <=
                                rx_next[`SNVC_ST_GUARD];
                            spare_q <= rx_next[`SNVC_ST_SPARE_HI:
                                               `SNVC_ST_SPARE_LO];
                            block_guard_q <= rx_next[`SNVC_ST_BLK_HI:
                                               `SNVC_ST_BLK_LO];
                        end
                    end
                end
                ST_MWRITE: begin
                    if (cnt_q == `SNVC_BYTE_LAST) begin
                        cnt_q    <= 4'h0;
                        // range mapping lives outside
                        mem_wr_q <= wel_q && write_region_ok;
                        mem_wd_q <= rx_next;
                    end
                end
                ST_SREAD, ST_MREAD, ST_DONE: begin
                    cnt_q <= 4'h0;
                end
                default: begin
                    state_q <= ST_DONE;
                end
                endcase
            end
            // next write byte goes one address up, wrapping at top
            if (mem_wr_q) begin
                mem_wa_q <= mem_wa_q + {{(`SNVC_AW-1){1'b0}}, 1'b1};
            end
        end
    end

    // ----------------------------------------------------------------
    // read-ahead into the buffer
    // ----------------------------------------------------------------
    // one fetch in flight at a time so a push never meets a full buffer
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_pend_q  <= 1'b0;
            inflight_q <= 1'b0;
            rd_addr_q  <= {`SNVC_AW{1'b0}};
        end else if (flush) begin
            rd_pend_q  <= 1'b0;
            inflight_q <= 1'b0;
        end else begin
            inflight_q <= mem_rd_en;
            if (sck_rise && state_q == ST_ADDR &&
                cnt_q == `SNVC_ADDR_LAST && !wr_seen_q) begin
                rd_pend_q <= 1'b1;
                rd_addr_q <= {addr_q[`SNVC_AW-2:0], si_s2_q};
            end else if (mem_rd_en) begin
                rd_addr_q <= rd_addr_q +
                             {{(`SNVC_AW-1){1'b0}}, 1'b1};
            end
        end
    end

    // ----------------------------------------------------------------
    // falling-edge output shifter
    // ----------------------------------------------------------------
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            tx_q     <= 8'h00;
            tx_cnt_q <= 3'h0;
            so_q     <= 1'b0;
            so_oe_q  <= 1'b0;
        end else begin
            // released while deselected or held
            so_oe_q <= active && is_out_state(state_q);
            if (cs_s2_q) begin
                tx_cnt_q <= 3'h0;
            end else if (sck_fall && is_out_state(state_q)) begin
                if (tx_cnt_q == 3'h0) begin
                    // a fresh byte each eight falls: repeat or next
                    tx_q     <= state_q == ST_SREAD ? status_view
                                : buf_out_data;
                    so_q     <= state_q == ST_SREAD ? status_view[7]
                                : buf_out_data[7];
                    tx_cnt_q <= 3'h7;
                end else begin
                    so_q     <= tx_q[6];
                    tx_q     <= {tx_q[6:0], 1'b0};
                    tx_cnt_q <= tx_cnt_q - 3'h1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // storage array and read buffer
    // ----------------------------------------------------------------
    snvc_mem u_mem (
        .clk       (clk),
        .wr_en     (mem_wr_q),
        .wr_addr   (mem_wa_q),
        .wr_data   (mem_wd_q),
        .rd_en     (mem_rd_en),
        .rd_addr   (rd_addr_q),
        .rd_data_q (mem_rd_data)
    );

    snvc_buf2 u_buf (
        .clk       (clk),
        .reset     (reset),
        .flush     (flush),
        .in_valid  (inflight_q),
        .in_ready  (buf_in_ready),
        .in_data   (mem_rd_data),
        .out_valid (buf_out_valid),
        .out_ready (pop),
        .out_data  (buf_out_data)
    );

endmodule // snvc_slave
`default_nettype wire

// ### snvc_slave_chk.sv
// Purpose: pin timing checks for the serial nonvolatile command slave
// Assumes: mode 0 or 3 host, sck period far longer than sync latency
// Notes:   bounds allow two sync flops plus one edge-detect stage
`timescale 1ns/100ps
`default_nettype none

module snvc_slave_chk (
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       sck,
    input wire logic       cs_n,
    input wire logic       si,
    input wire logic       hold_n,
    input wire logic       wp_n,
    input wire logic       write_region_ok,
    input wire logic       so_q,
    input wire logic       so_oe_q,
    input wire logic [1:0] block_guard_q,
    input wire logic       status_write_guard_q
);
    // ------------------------------------------------------------
    // assertions, all in the clk domain
    // ------------------------------------------------------------
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (reset);

    a_idle_released: assert property
        (cs_n [*6] |-> !so_oe_q)
        else $error("output enabled while deselected");
    a_release_bound: assert property
        ($rose(cs_n) |-> ##[1:6] !so_oe_q)
        else $error("output not released after select rise");
    a_oe_start_select: assert property
        ($rose(so_oe_q) |-> !cs_n && hold_n)
        else $error("output enabled without select");
    a_hold_release: assert property
        ($fell(hold_n) && !cs_n ##1 !hold_n [*6] |-> !so_oe_q)
        else $error("output still driven during hold");
    a_hold_quiet: assert property
        (!hold_n [*6] |-> $stable(so_q))
        else $error("serial output moved during hold");
    // data may only move while the clock sits low after a fall
    a_so_fall_only: assert property
        (so_oe_q && $past(so_oe_q) && $changed(so_q) |-> !sck)
        else $error("serial output changed while clock high");
    a_store_on_rise: assert property
        ($changed({status_write_guard_q, block_guard_q}) |-> !cs_n && sck)
        else $error("status bits changed outside a rising edge");
    a_store_guarded: assert property
        ($changed({status_write_guard_q, block_guard_q})
            |-> !($past(status_write_guard_q) && !wp_n))
        else $error("status written while guarded");
endmodule // snvc_slave_chk

bind snvc_slave snvc_slave_chk snvc_slave_chk_i (
    .clk(clk), .reset(reset), .sck(sck), .cs_n(cs_n), .si(si),
    .hold_n(hold_n), .wp_n(wp_n), .write_region_ok(write_region_ok),
    .so_q(so_q), .so_oe_q(so_oe_q), .block_guard_q(block_guard_q),
    .status_write_guard_q(status_write_guard_q));

`default_nettype wire

// ### snvc_slave_test.sv
// Purpose: self-checking bench for the serial nonvolatile command slave
// Assumes: host model drives every serial pin
// Notes:   memory contents are unknown after reset, so written first
`timescale 1ns/100ps
`default_nettype none
`include "snvc_defs.vh"

`define SNVC_CHK(got, exp) \
    begin \
        check_count++; \
        if ((got) !== (exp)) begin \
            fail_count++; \
            $display("wrong value at %0t: got %h expected %h", \
                     $time, got, exp); \
        end \
    end

module snvc_slave_test;
    logic       clk;
    logic       reset;
    logic       write_region_ok;
    wire        sck, cs_n, si, hold_n, wp_n, so_q, so_oe_q;
    wire        status_write_guard_q;
    wire  [1:0] block_guard_q;
    int         fail_count;
    int         check_count;
    logic [7:0] r, d0, d1;

    snvc_slave snvc_slave_i (.clk(clk), .reset(reset), .sck(sck),
        .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n),
        .write_region_ok(write_region_ok), .so_q(so_q),
        .so_oe_q(so_oe_q), .block_guard_q(block_guard_q),
        .status_write_guard_q(status_write_guard_q));

    snvc_host snvc_host_i (.clk(clk), .so(so_q), .so_oe(so_oe_q),
        .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n));

    // ------------------------------------------------------------
    // clock, frame helpers and verdict
    // ------------------------------------------------------------
    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    task automatic cmd(input logic [7:0] op);
        logic [7:0] x;
        snvc_host_i.start();
        snvc_host_i.shift(op, 8, x);
        snvc_host_i.stop();
    endtask

    task automatic rd_status(output logic [7:0] v);
        logic [7:0] x;
        snvc_host_i.start();
        snvc_host_i.shift(`SNVC_OP_STAT_READ, 8, x);
        snvc_host_i.shift(8'h00, 8, v);
        snvc_host_i.stop();
    endtask

    task automatic wr_status(input logic [7:0] v);
        logic [7:0] x;
        snvc_host_i.start();
        snvc_host_i.shift(`SNVC_OP_STAT_WRITE, 8, x);
        snvc_host_i.shift(v, 8, x);
        snvc_host_i.stop();
    endtask

    // opcode, 16-bit address, then two data bytes each way
    task automatic mem(input logic [7:0] op, input logic [15:0] a,
                       input logic [7:0] w0, input logic [7:0] w1,
                       output logic [7:0] q0, output logic [7:0] q1);
        logic [7:0] x;
        snvc_host_i.start();
        snvc_host_i.shift(op, 8, x);
        snvc_host_i.shift(a[15:8], 8, x);
        snvc_host_i.shift(a[7:0], 8, x);
        snvc_host_i.shift(w0, 8, q0);
        snvc_host_i.shift(w1, 8, q1);
        snvc_host_i.stop();
    endtask

    task automatic wrap_up();
        if ((fail_count == 0) && (check_count > 0)) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // hang guard, about four times the expected run
    initial begin
        #200_000;
        fail_count++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        fail_count = 0;
        check_count = 0;
        reset = 1'b1;
        write_region_ok = 1'b1;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        rd_status(r); `SNVC_CHK(r, `SNVC_ST_RESET)
        cmd(`SNVC_OP_SET_LATCH);
        rd_status(r); `SNVC_CHK(r, 8'h02)
        cmd(`SNVC_OP_CLR_LATCH);
        rd_status(r); `SNVC_CHK(r, 8'h00)
        // set-latch opcode cut one bit short must do nothing
        snvc_host_i.start();
        snvc_host_i.shift(`SNVC_OP_SET_LATCH, 7, r);
        snvc_host_i.stop();
        rd_status(r); `SNVC_CHK(r, 8'h00)
        wr_status(8'hFF);
        rd_status(r); `SNVC_CHK(r, 8'h00)
        cmd(`SNVC_OP_SET_LATCH);
        wr_status(8'hFF);
        rd_status(r); `SNVC_CHK(r, 8'hFC)
        `SNVC_CHK(({status_write_guard_q, block_guard_q}), 3'b111)
        snvc_host_i.set_wp(1'b0);
        cmd(`SNVC_OP_SET_LATCH);
        wr_status(8'h00);
        rd_status(r); `SNVC_CHK(r, 8'hFC)
        snvc_host_i.set_wp(1'b1);
        cmd(`SNVC_OP_SET_LATCH);
        wr_status(8'h73);
        rd_status(r); `SNVC_CHK(r, 8'h70)
        // top address then wrap to zero; upper address bits ignored
        cmd(`SNVC_OP_SET_LATCH);
        mem(`SNVC_OP_MEM_WRITE, 16'hFFFF, 8'hA5, 8'h5A, d0, d1);
        rd_status(r); `SNVC_CHK(r, 8'h70)
        mem(`SNVC_OP_MEM_WRITE, 16'h07FF, 8'h00, 8'h00, d0, d1);
        cmd(`SNVC_OP_SET_LATCH);
        write_region_ok <= 1'b0;
        mem(`SNVC_OP_MEM_WRITE, 16'h0000, 8'h11, 8'h22, d0, d1);
        write_region_ok <= 1'b1;
        mem(`SNVC_OP_MEM_READ, 16'hF7FF, 8'hFF, 8'hFF, d0, d1);
        `SNVC_CHK(d0, 8'hA5)
        `SNVC_CHK(d1, 8'h5A)
        // same reads with the clock parked high between frames
        snvc_host_i.set_mode(1'b1);
        rd_status(r); `SNVC_CHK(r, 8'h70)
        mem(`SNVC_OP_MEM_READ, 16'h07FF, 8'h00, 8'h00, d0, d1);
        `SNVC_CHK(d0, 8'hA5)
        `SNVC_CHK(d1, 8'h5A)
        snvc_host_i.set_mode(1'b0);
        // status byte repeats, with a hold between the copies
        snvc_host_i.start();
        snvc_host_i.shift(`SNVC_OP_STAT_READ, 8, r);
        snvc_host_i.shift(8'hFF, 8, d0);
        snvc_host_i.pause();
        snvc_host_i.shift(8'hFF, 8, d1);
        snvc_host_i.stop();
        `SNVC_CHK(d0, 8'h70)
        `SNVC_CHK(d1, 8'h70)
        cmd(`SNVC_OP_IDENT_READ);
        rd_status(r); `SNVC_CHK(r, 8'h70)
        wrap_up();
    end
endmodule // snvc_slave_test

`default_nettype wire
